// File: core/ssf_pkg.sv
//------------------------------------------------------------
// constants and types
//------------------------------------------------------------
// Contract
// - six 16-bit segment registers: code, data, stack, extra, two auxiliary data.
// - data references default to data segment, stack references to stack segment.
// - code fetches always use code segment; overrides never apply.
// - push, pop, call, return, interrupt stack accesses always use stack segment.
// - string-store and string-move destinations always use extra segment.
// - other data references default to data; an override may redirect them.
// - next offset advances by instruction length unless execution is redirected.
// - low half of flags is the legacy 16-bit flags register.
// - bit 21 writable only when feature query enable is set.
// - bit 18 with align mask set faults misaligned accesses.
// - bit 17 in protected mode: legacy segment loads, privileged opcodes fault 13.
// - bit 17 set only by interrupt return at level 0 or task switch.
// - bit 16 set at a boundary suppresses debug faults of next instruction.
// - bit 14 in protected mode marks a nested task.
// - io instructions above level in bits 13:12 fault 13 or check bitmap.
// - popped interrupt enable changes only when privilege is at or below bits 13:12.
// - bit 11 set when carry into sign differs from carry out of top.
// - bit 10 clear increments string indexes, set decrements them.
// - bit 9 set lets maskable interrupts be acknowledged, clear holds them off.
// - bit 8 raises single-step trap after next instruction; trap clears it.
package ssf_pkg;
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_NEXT = 8'h04;
  localparam logic [7:0] OFF_SEG_BASE = 8'h08;
  localparam logic [7:0] OFF_SEG_LAST = 8'h1C;
  localparam logic [7:0] OFF_CONFIG = 8'h20;
  localparam int FB_TF = 8;
  localparam int FB_IF = 9;
  localparam int FB_DF = 10;
  localparam int FB_OF = 11;
  localparam int FB_IO_PRIVILEGE_LEVEL = 12;
  localparam int FB_NT = 14;
  localparam int FB_RF = 16;
  localparam int FB_VM = 17;
  localparam int FB_AC = 18;
  localparam int FB_ID = 21;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] FLAGS_WMASK = 32'h0027_7FD5;
  localparam logic [31:0] FLAGS_FIXED1 = 32'h0000_0002;
  localparam int CFG_PROT = 0;
  localparam int CFG_CPL = 1;
  localparam int CFG_FQ = 7;
  localparam int CFG_AM = 18;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] NEXT_RESET = 32'h0000_0000;
  localparam logic [15:0] SEG_RESET = 16'h0000;
  localparam logic [7:0] GP_VECTOR = 8'h0D;
  typedef enum logic [2:0] {
    SEG_CODE, SEG_STACK, SEG_DATA, SEG_EXTRA, SEG_AUX1, SEG_AUX2
  } ssf_seg_t;
  typedef enum logic [2:0] {
    REF_CODE, REF_PUSH, REF_POP, REF_STR_DEST, REF_DATA, REF_STACK_DATA
  } ssf_ref_t;
endpackage

// File: core/ssf_core.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ssf_core (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic ref_valid_in,
  input wire logic [2:0] ref_kind_in,
  input wire logic ovr_prefix_in,
  input wire logic [2:0] ovr_seg_in,
  output logic [2:0] seg_idx_out,
  output logic [15:0] seg_value_out,
  input wire logic seg_load_in,
  input wire logic [2:0] seg_load_idx_in,
  input wire logic [15:0] seg_load_value_in,
  input wire logic retire_in,
  input wire logic [3:0] instr_len_in,
  input wire logic redirect_in,
  input wire logic [31:0] redirect_target_in,
  output logic [31:0] next_instr_offset_out,
  input wire logic pop_flags_in,
  input wire logic iret_in,
  input wire logic task_switch_in,
  input wire logic [31:0] flags_value_in,
  input wire logic alu_valid_in,
  input wire logic carry_into_sign_in,
  input wire logic carry_out_top_in,
  input wire logic access_valid_in,
  input wire logic access_misaligned_in,
  input wire logic priv_op_in,
  input wire logic io_instr_in,
  input wire logic breakpoint_hit_in,
  input wire logic maskable_irq_input_in,
  output logic [31:0] flags_out,
  output logic [15:0] legacy_flags_out,
  output logic align_fault_out,
  output logic gp_fault_out,
  output logic io_deny_out,
  output logic [7:0] gp_vector_out,
  output logic debug_fault_out,
  output logic irq_ack_out,
  output logic step_trap_out,
  output logic legacy_seg_load_out,
  output logic nested_task_out,
  output logic idx_decrement_out
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  logic [31:0] flags_reg;
  logic [31:0] flags_next;
  logic [31:0] loaded;
  logic [31:0] next_off_reg;
  logic [31:0] config_reg;
  logic [15:0] seg_reg [0:5];
  logic ovr_valid_reg;
  logic [2:0] ovr_seg_reg;
  logic [31:0] rdata_reg;
  logic [2:0] seg_idx_reg;
  logic [15:0] seg_value_reg;
  logic align_fault_reg;
  logic gp_fault_reg;
  logic io_deny_reg;
  logic debug_fault_reg;
  logic irq_ack_reg;
  logic step_trap_reg;
  logic [2:0] sel_next;
  logic [1:0] current_privilege;
  logic [1:0] io_privilege_level;
  logic prot;
  logic seg_bus_hit;
  logic [7:0] seg_bus_off;
  logic [2:0] seg_bus_idx;
  logic load_any;
  logic vm_allowed;
  ssf_pkg::ssf_ref_t kind;

  assign current_privilege = config_reg[ssf_pkg::CFG_CPL +: 2];
  assign io_privilege_level = flags_reg[ssf_pkg::FB_IO_PRIVILEGE_LEVEL +: 2];
  assign prot = config_reg[ssf_pkg::CFG_PROT];
  assign kind = ssf_pkg::ssf_ref_t'(ref_kind_in);
  assign seg_bus_off = addr_in - ssf_pkg::OFF_SEG_BASE;
  assign seg_bus_idx = seg_bus_off[4:2];
  assign seg_bus_hit = (addr_in >= ssf_pkg::OFF_SEG_BASE) && (addr_in <= ssf_pkg::OFF_SEG_LAST)
                       && (addr_in[1:0] == 2'b00);
  assign load_any = pop_flags_in || task_switch_in || (wr_in && addr_in == ssf_pkg::OFF_FLAGS);
  assign vm_allowed = task_switch_in || (iret_in && pop_flags_in && current_privilege == 2'd0);

  //------------------------------------------------------------
  // register bus
  //------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      config_reg <= ssf_pkg::CONFIG_RESET;
    end else if (ce_in && wr_in && addr_in == ssf_pkg::OFF_CONFIG) begin
      config_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata_reg <= 32'h0000_0000;
      if (rd_in) begin
        if (addr_in == ssf_pkg::OFF_FLAGS) begin
          rdata_reg <= flags_reg;
        end else if (addr_in == ssf_pkg::OFF_NEXT) begin
          rdata_reg <= next_off_reg;
        end else if (addr_in == ssf_pkg::OFF_CONFIG) begin
          rdata_reg <= config_reg;
        end else if (seg_bus_hit) begin
          rdata_reg <= {16'h0000, seg_reg[seg_bus_idx]};
        end
      end
    end
  end

  //------------------------------------------------------------
  // segment registers
  //------------------------------------------------------------
  // six selectors
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 6; i++) begin
        seg_reg[i] <= ssf_pkg::SEG_RESET;
      end
    end else if (ce_in) begin
      if (seg_load_in && seg_load_idx_in <= 3'd5) begin
        seg_reg[seg_load_idx_in] <= seg_load_value_in;
      end else if (wr_in && seg_bus_hit) begin
        seg_reg[seg_bus_idx] <= wdata_in[15:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ovr_valid_reg <= 1'b0;
      ovr_seg_reg <= 3'd0;
    end else if (ce_in) begin
      if (ovr_prefix_in && ovr_seg_in <= 3'd5) begin
        ovr_valid_reg <= 1'b1;
        ovr_seg_reg <= ovr_seg_in;
      end else if (retire_in || redirect_in) begin
        ovr_valid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    sel_next = ssf_pkg::SEG_DATA;
    case (kind)
      ssf_pkg::REF_CODE: sel_next = ssf_pkg::SEG_CODE;
      ssf_pkg::REF_PUSH, ssf_pkg::REF_POP: sel_next = ssf_pkg::SEG_STACK;
      ssf_pkg::REF_STR_DEST: sel_next = ssf_pkg::SEG_EXTRA;
      ssf_pkg::REF_STACK_DATA: sel_next = ovr_valid_reg ? ovr_seg_reg : ssf_pkg::SEG_STACK;
      ssf_pkg::REF_DATA: sel_next = ovr_valid_reg ? ovr_seg_reg : ssf_pkg::SEG_DATA;
      default: sel_next = ssf_pkg::SEG_DATA;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      seg_idx_reg <= ssf_pkg::SEG_CODE;
      seg_value_reg <= ssf_pkg::SEG_RESET;
    end else if (ce_in && ref_valid_in) begin
      seg_idx_reg <= sel_next;
      seg_value_reg <= seg_reg[sel_next];
    end
  end

  //------------------------------------------------------------
  // next instruction offset
  //------------------------------------------------------------
  // advance or redirect
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      next_off_reg <= ssf_pkg::NEXT_RESET;
    end else if (ce_in) begin
      if (redirect_in) begin
        next_off_reg <= redirect_target_in;
      end else if (retire_in) begin
        next_off_reg <= next_off_reg + {28'h000_0000, instr_len_in};
      end else if (wr_in && addr_in == ssf_pkg::OFF_NEXT) begin
        next_off_reg <= wdata_in;
      end
    end
  end

  //------------------------------------------------------------
  // flags
  //------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    loaded = flags_reg;
    if (alu_valid_in) begin
      flags_next[ssf_pkg::FB_OF] = carry_into_sign_in ^ carry_out_top_in;
    end
    if (retire_in) begin
      flags_next[ssf_pkg::FB_RF] = 1'b0;
      if (flags_reg[ssf_pkg::FB_TF]) begin
        flags_next[ssf_pkg::FB_TF] = 1'b0;
      end
    end
    if (load_any) begin
      loaded = (pop_flags_in || task_switch_in) ? flags_value_in : wdata_in;
      loaded = (loaded & ssf_pkg::FLAGS_WMASK) | ssf_pkg::FLAGS_FIXED1;
      if (!config_reg[ssf_pkg::CFG_FQ]) begin
        loaded[ssf_pkg::FB_ID] = flags_reg[ssf_pkg::FB_ID];
      end
      if (!vm_allowed) begin
        loaded[ssf_pkg::FB_VM] = flags_reg[ssf_pkg::FB_VM] & loaded[ssf_pkg::FB_VM];
      end
      if (pop_flags_in && !task_switch_in && current_privilege > io_privilege_level) begin
        loaded[ssf_pkg::FB_IF] = flags_reg[ssf_pkg::FB_IF];
      end
      flags_next = loaded;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flags_reg <= ssf_pkg::FLAGS_RESET;
    end else if (ce_in) begin
      flags_reg <= flags_next;
    end
  end

  //------------------------------------------------------------
  // events and faults
  //------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      align_fault_reg <= 1'b0;
      gp_fault_reg <= 1'b0;
      io_deny_reg <= 1'b0;
    end else if (ce_in) begin
      align_fault_reg <= access_valid_in && access_misaligned_in && flags_reg[ssf_pkg::FB_AC]
                         && config_reg[ssf_pkg::CFG_AM];
      io_deny_reg <= io_instr_in && prot && current_privilege > io_privilege_level;
      gp_fault_reg <= (priv_op_in && prot && flags_reg[ssf_pkg::FB_VM])
                      || (io_instr_in && prot && current_privilege > io_privilege_level);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      debug_fault_reg <= 1'b0;
      irq_ack_reg <= 1'b0;
      step_trap_reg <= 1'b0;
    end else if (ce_in) begin
      debug_fault_reg <= breakpoint_hit_in && !flags_reg[ssf_pkg::FB_RF];
      irq_ack_reg <= retire_in && maskable_irq_input_in && flags_reg[ssf_pkg::FB_IF];
      step_trap_reg <= retire_in && flags_reg[ssf_pkg::FB_TF];
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign rdata_out = rdata_reg;
  assign seg_idx_out = seg_idx_reg;
  assign seg_value_out = seg_value_reg;
  assign next_instr_offset_out = next_off_reg;
  assign flags_out = flags_reg;
  assign legacy_flags_out = flags_reg[15:0];
  assign align_fault_out = align_fault_reg;
  assign gp_fault_out = gp_fault_reg;
  assign io_deny_out = io_deny_reg;
  assign gp_vector_out = ssf_pkg::GP_VECTOR;
  assign debug_fault_out = debug_fault_reg;
  assign irq_ack_out = irq_ack_reg;
  assign step_trap_out = step_trap_reg;
  assign legacy_seg_load_out = prot && flags_reg[ssf_pkg::FB_VM];
  assign nested_task_out = prot && flags_reg[ssf_pkg::FB_NT];
  assign idx_decrement_out = flags_reg[ssf_pkg::FB_DF];

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in || !ce_in);

  sequence step_retire_s;
    retire_in && flags_reg[ssf_pkg::FB_TF];
  endsequence

  sequence step_fire_s;
    step_trap_out;
  endsequence

  code_fetch_seg_a: assert property (
    ref_valid_in && kind == ssf_pkg::REF_CODE |=> seg_idx_out == ssf_pkg::SEG_CODE)
    else $error("code fetch not on code segment");

  stack_fixed_seg_a: assert property (
    ref_valid_in && (kind == ssf_pkg::REF_PUSH || kind == ssf_pkg::REF_POP)
    |=> seg_idx_out == ssf_pkg::SEG_STACK && seg_value_out == $past(seg_reg[1]))
    else $error("stack access not on stack segment");

  str_dest_seg_a: assert property (
    ref_valid_in && kind == ssf_pkg::REF_STR_DEST |=> seg_idx_out == ssf_pkg::SEG_EXTRA)
    else $error("string destination not on extra segment");

  data_default_a: assert property (
    ref_valid_in && kind == ssf_pkg::REF_DATA && !ovr_valid_reg
    |=> seg_idx_out == ssf_pkg::SEG_DATA)
    else $error("data default segment wrong");

  override_clear_a: assert property (
    retire_in && !ovr_prefix_in |=> !ovr_valid_reg)
    else $error("override outlived its instruction");

  query_lock_a: assert property (
    !config_reg[ssf_pkg::CFG_FQ] |=> $stable(flags_reg[ssf_pkg::FB_ID]))
    else $error("query bit changed while locked");

  align_fault_a: assert property (
    access_valid_in && access_misaligned_in && flags_reg[ssf_pkg::FB_AC]
    && config_reg[ssf_pkg::CFG_AM] |=> align_fault_out)
    else $error("misaligned access not faulted");

  vm_set_path_a: assert property (
    $rose(flags_reg[ssf_pkg::FB_VM]) |-> $past(vm_allowed))
    else $error("emulation bit set by illegal path");

  rf_suppress_a: assert property (
    flags_reg[ssf_pkg::FB_RF] && breakpoint_hit_in |=> !debug_fault_out)
    else $error("debug fault not suppressed");

  step_trap_a: assert property (
    (step_retire_s and !load_any) |=> step_fire_s ##0 !flags_reg[ssf_pkg::FB_TF])
    else $error("single step trap missing");

  irq_hold_a: assert property (
    !flags_reg[ssf_pkg::FB_IF] |=> !irq_ack_out)
    else $error("interrupt acknowledged while held off");

  next_adv_a: assert property (
    retire_in && !redirect_in |=> next_instr_offset_out == $past(next_off_reg)
    + {28'h000_0000, $past(instr_len_in)})
    else $error("next offset did not advance");

  rsvd_zero_a: assert property (
    (flags_out & ~(ssf_pkg::FLAGS_WMASK | ssf_pkg::FLAGS_FIXED1)) == 32'h0000_0000)
    else $error("reserved flag bit set");

  overflow_a: assert property (
    alu_valid_in && !load_any |=> flags_reg[ssf_pkg::FB_OF]
    == ($past(carry_into_sign_in) ^ $past(carry_out_top_in)))
    else $error("overflow flag wrong");

endmodule

// File: sim/segment_select_and_flags_tb.sv
`timescale 1ns/100ps
module segment_select_and_flags_tb;
  logic clk_in, reset_in, ce_in, wr_in, rd_in, ref_valid_in, ovr_prefix_in, seg_load_in, retire_in, redirect_in;
  logic pop_flags_in, iret_in, task_switch_in, alu_valid_in, carry_into_sign_in, carry_out_top_in;
  logic access_valid_in, access_misaligned_in, priv_op_in, io_instr_in, breakpoint_hit_in, maskable_irq_input_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, redirect_target_in, flags_value_in, rdata_out, next_instr_offset_out, flags_out;
  logic [2:0] ref_kind_in, ovr_seg_in, seg_load_idx_in, seg_idx_out;
  logic [15:0] seg_load_value_in, seg_value_out, legacy_flags_out;
  logic [3:0] instr_len_in;
  logic align_fault_out, gp_fault_out, io_deny_out, debug_fault_out, irq_ack_out, step_trap_out;
  logic legacy_seg_load_out, nested_task_out, idx_decrement_out;
  logic [7:0] gp_vector_out;
  int err_count = 0;
  int total_checks = 0;
  ssf_core ssf_core_inst (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ref_valid_in(ref_valid_in),
    .ref_kind_in(ref_kind_in), .ovr_prefix_in(ovr_prefix_in), .ovr_seg_in(ovr_seg_in), .seg_idx_out(seg_idx_out),
    .seg_value_out(seg_value_out), .seg_load_in(seg_load_in), .seg_load_idx_in(seg_load_idx_in),
    .seg_load_value_in(seg_load_value_in), .retire_in(retire_in), .instr_len_in(instr_len_in),
    .redirect_in(redirect_in), .redirect_target_in(redirect_target_in),
    .next_instr_offset_out(next_instr_offset_out), .pop_flags_in(pop_flags_in), .iret_in(iret_in),
    .task_switch_in(task_switch_in), .flags_value_in(flags_value_in), .alu_valid_in(alu_valid_in),
    .carry_into_sign_in(carry_into_sign_in), .carry_out_top_in(carry_out_top_in),
    .access_valid_in(access_valid_in), .access_misaligned_in(access_misaligned_in), .priv_op_in(priv_op_in),
    .io_instr_in(io_instr_in), .breakpoint_hit_in(breakpoint_hit_in),
    .maskable_irq_input_in(maskable_irq_input_in), .flags_out(flags_out), .legacy_flags_out(legacy_flags_out),
    .align_fault_out(align_fault_out), .gp_fault_out(gp_fault_out), .io_deny_out(io_deny_out),
    .gp_vector_out(gp_vector_out), .debug_fault_out(debug_fault_out), .irq_ack_out(irq_ack_out),
    .step_trap_out(step_trap_out), .legacy_seg_load_out(legacy_seg_load_out),
    .nested_task_out(nested_task_out), .idx_decrement_out(idx_decrement_out));
  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // next edge: drop every pulse, let the edge settle
  task automatic cyc();
    @(posedge clk_in);
    {wr_in, rd_in, ref_valid_in, ovr_prefix_in, seg_load_in, retire_in, redirect_in} <= '0;
    {pop_flags_in, iret_in, task_switch_in, alu_valid_in, access_valid_in, priv_op_in} <= '0;
    {io_instr_in, breakpoint_hit_in} <= '0;
    #1;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    cyc();
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    cyc();
    d = rdata_out;
  endtask
  task automatic pop(input logic [31:0] v, input logic ir);
    @(posedge clk_in);
    pop_flags_in <= 1'b1;
    iret_in <= ir;
    flags_value_in <= v;
    cyc();
  endtask
  task automatic retire(input logic [3:0] len);
    @(posedge clk_in);
    retire_in <= 1'b1;
    instr_len_in <= len;
    cyc();
  endtask
  function automatic logic [15:0] segv(int i);
    return 16'(16'h1111 * (i + 1));
  endfunction
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    bus_rd(ssf_pkg::OFF_FLAGS, d);
    chk(d, 32'h0000_0002);
    bus_rd(8'h24, d);
    chk(d, 32'h0000_0000);
    bus_wr(ssf_pkg::OFF_FLAGS, 32'hFFFF_FFFF);
    bus_rd(ssf_pkg::OFF_FLAGS, d);
    chk(d, 32'h0005_7FD7);
    bus_wr(ssf_pkg::OFF_CONFIG, 32'h0000_0081);
    bus_wr(ssf_pkg::OFF_FLAGS, 32'hFFFF_FFFF);
    chk(flags_out, 32'h0025_7FD7);
    chk(legacy_flags_out, 16'h7FD7);
    chk({nested_task_out, idx_decrement_out}, 2'b11);
    @(posedge clk_in);
    breakpoint_hit_in <= 1'b1;
    access_valid_in <= 1'b1;
    access_misaligned_in <= 1'b1;
    cyc();
    chk({debug_fault_out, align_fault_out}, 2'b00);
    bus_wr(ssf_pkg::OFF_CONFIG, 32'h0004_0081);
    @(posedge clk_in);
    access_valid_in <= 1'b1;
    cyc();
    chk(align_fault_out, 1);
    bus_wr(ssf_pkg::OFF_FLAGS, 32'h0000_0000);
    chk({nested_task_out, idx_decrement_out}, 2'b00);
    @(posedge clk_in);
    breakpoint_hit_in <= 1'b1;
    access_valid_in <= 1'b1;
    cyc();
    chk({debug_fault_out, align_fault_out}, 2'b10);
    chk(gp_vector_out, 8'h0D);
  endtask
  task automatic t_priv();
    bus_wr(ssf_pkg::OFF_CONFIG, 32'h0000_0087);
    @(posedge clk_in);
    io_instr_in <= 1'b1;
    cyc();
    chk({io_deny_out, gp_fault_out}, 2'b11);
    pop(32'h0000_0200, 1'b0);
    chk(flags_out, 32'h0000_0002);
    pop(32'h0002_0002, 1'b1);
    chk(flags_out, 32'h0000_0002);
    @(posedge clk_in);
    task_switch_in <= 1'b1;
    flags_value_in <= 32'h0002_0002;
    cyc();
    chk(flags_out, 32'h0002_0002);
    chk(legacy_seg_load_out, 1);
    @(posedge clk_in);
    priv_op_in <= 1'b1;
    cyc();
    chk(gp_fault_out, 1);
    bus_wr(ssf_pkg::OFF_CONFIG, 32'h0000_0081);
    pop(32'h0000_3202, 1'b0);
    chk(flags_out, 32'h0000_3202);
    @(posedge clk_in);
    io_instr_in <= 1'b1;
    cyc();
    chk({io_deny_out, gp_fault_out}, 2'b00);
    pop(32'h0002_0202, 1'b1);
    chk(flags_out, 32'h0002_0202);
  endtask
  task automatic t_step();
    pop(32'h0000_0302, 1'b0);
    @(posedge clk_in);
    maskable_irq_input_in <= 1'b1;
    retire_in <= 1'b1;
    instr_len_in <= 4'h1;
    cyc();
    chk({step_trap_out, irq_ack_out}, 2'b11);
    chk(flags_out, 32'h0000_0202);
    retire(4'h1);
    chk({step_trap_out, irq_ack_out}, 2'b01);
    pop(32'h0000_0002, 1'b0);
    retire(4'h1);
    chk(irq_ack_out, 0);
  endtask
  task automatic t_over();
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_in);
      alu_valid_in <= 1'b1;
      carry_into_sign_in <= c[0];
      carry_out_top_in <= c[1];
      cyc();
      chk(flags_out[ssf_pkg::FB_OF], c[0] ^ c[1]);
    end
  endtask
  task automatic t_offset();
    logic [31:0] b;
    bus_wr(ssf_pkg::OFF_NEXT, 32'h0000_0100);
    retire(4'hF);
    chk(next_instr_offset_out, 32'h0000_010F);
    @(posedge clk_in);
    retire_in <= 1'b1;
    instr_len_in <= 4'h3;
    redirect_in <= 1'b1;
    redirect_target_in <= 32'h0000_1234;
    cyc();
    chk(next_instr_offset_out, 32'h0000_1234);
    bus_rd(ssf_pkg::OFF_NEXT, b);
    chk(b, 32'h0000_1234);
    cyc();
    chk(rdata_out, 32'h0000_0000);
    @(posedge clk_in);
    ce_in <= 1'b0;
    retire_in <= 1'b1;
    instr_len_in <= 4'h2;
    cyc();
    chk(next_instr_offset_out, 32'h0000_1234);
    @(posedge clk_in);
    ce_in <= 1'b1;
  endtask
  task automatic t_seg();
    logic [2:0] e;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      seg_load_in <= 1'b1;
      seg_load_idx_in <= 3'(i);
      seg_load_value_in <= segv(i);
      cyc();
    end
    bus_rd(8'h14, d);
    chk(d, {16'h0000, segv(3)});
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 7; j++) begin
        if (j > 0) begin
          @(posedge clk_in);
          ovr_prefix_in <= 1'b1;
          ovr_seg_in <= 3'(j - 1);
          cyc();
        end
        @(posedge clk_in);
        ref_valid_in <= 1'b1;
        ref_kind_in <= 3'(k);
        cyc();
        // code 0, stack 1, data 2, extra 3, aux 4 and 5
        case (k)
          0: e = 3'd0;
          1, 2: e = 3'd1;
          3: e = 3'd3;
          4: e = (j > 0) ? 3'(j - 1) : 3'd2;
          default: e = (j > 0) ? 3'(j - 1) : 3'd1;
        endcase
        chk({seg_idx_out, seg_value_out}, {e, segv(e)});
        retire(4'h1);
      end
    end
  endtask
  //------------------------------------------------------------
  // run
  //------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    {reset_in, ce_in} = 2'b11;
    {wr_in, rd_in, ref_valid_in, ovr_prefix_in, seg_load_in, retire_in, redirect_in} = '0;
    {pop_flags_in, iret_in, task_switch_in, alu_valid_in, carry_into_sign_in, carry_out_top_in} = '0;
    {access_valid_in, access_misaligned_in, priv_op_in, io_instr_in, breakpoint_hit_in} = '0;
    maskable_irq_input_in = 1'b0;
    addr_in = '0;
    wdata_in = '0;
    ref_kind_in = '0;
    ovr_seg_in = '0;
    seg_load_idx_in = '0;
    seg_load_value_in = '0;
    instr_len_in = '0;
    redirect_target_in = '0;
    flags_value_in = '0;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    t_regs();
    t_priv();
    t_step();
    t_over();
    t_offset();
    t_seg();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    conclude();
  end
endmodule
